/* hw/rsw_reset_status_wdog.sv */
/*
 Reset-cause status register, software watchdog enable, event interrupt.
 Assumes events are single-cycle pulses from logic on i_clk_sys; config inputs are static straps.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rsw_consts.svh"

// Behaviour
// - software enable matters only when config disables
// - writing one switches watchdog on
// - zero switches watchdog off, reset zero
// - watchdog control upper seven bits read zero
// - power-on flag loaded by reset kind
module rsw_reset_status_wdog (
  // Clock and reset
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_srst,
  // Register port
  input  wire rsw_pkg::rsw_bus_req_type i_bus,
  output logic [7:0]                    o_rdata,
  // Events and configuration
  input  wire rsw_pkg::rsw_event_type   i_evt,
  input  wire logic                     i_config_watchdog_enable,
  input  wire logic                     i_config_soft_brownout_allow,
  // Outputs
  output logic                          o_watchdog_run,
  output logic                          o_irq_priority_enable,
  output logic                          o_soft_brownout_enable,
  output logic                          o_irq
);
  import rsw_pkg::*;

  logic [7:0] reset_cause_status;
  logic       soft_watchdog_enable;
  logic [4:0] irq_status;
  logic [4:0] irq_mask;
  logic [4:0] flag_clear_evt;
  logic       wr_cause;
  logic       wr_wdog;
  logic       wr_stat;
  logic       wr_mask;

  assign wr_cause = i_bus.wr && (i_bus.addr == `RSW_ADDR_RESET_CAUSE);
  assign wr_wdog  = i_bus.wr && (i_bus.addr == `RSW_ADDR_WDOG_CTRL);
  assign wr_stat  = i_bus.wr && (i_bus.addr == `RSW_ADDR_IRQ_STATUS);
  assign wr_mask  = i_bus.wr && (i_bus.addr == `RSW_ADDR_IRQ_MASK);

  // Events that clear each flag, brown-out in bit zero up to reset-instruction
  assign flag_clear_evt = {i_evt.reset_instr, i_evt.wdt_timeout, i_evt.sleep_instr,
                           i_evt.power_on, i_evt.brownout || i_evt.power_on};

  ////////////////////////////////////////////////////////////////////////////
  // Reset-cause status register
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      reset_cause_status <= `RSW_RESET_CAUSE_RST;
      // Soft brown-out bit resets to one only where allowed
      reset_cause_status[`RSW_BIT_SOFT_BROWNOUT_EN] <= i_config_soft_brownout_allow;
    end else begin
      if (wr_cause) begin
        reset_cause_status[7:6] <= i_bus.wdata[7:6];
        // Software may only set flags back to one
        reset_cause_status[4:0] <= reset_cause_status[4:0] | i_bus.wdata[4:0];
      end
      if (!i_config_soft_brownout_allow) begin
        reset_cause_status[`RSW_BIT_SOFT_BROWNOUT_EN] <= 1'b0;
      end
      reset_cause_status[`RSW_BIT_UNUSED_CAUSE] <= 1'b0;
      // Hardware clear wins over software set
      if (i_evt.reset_instr) reset_cause_status[`RSW_BIT_RESET_INSTR] <= 1'b0;
      if (i_evt.wdt_timeout) reset_cause_status[`RSW_BIT_WDOG_TIMEOUT] <= 1'b0;
      else if (i_evt.wdt_clear || i_evt.sleep_instr || i_evt.power_on) begin
        reset_cause_status[`RSW_BIT_WDOG_TIMEOUT] <= 1'b1;
      end
      if (i_evt.sleep_instr) reset_cause_status[`RSW_BIT_POWER_DOWN] <= 1'b0;
      else if (i_evt.wdt_clear || i_evt.power_on) reset_cause_status[`RSW_BIT_POWER_DOWN] <= 1'b1;
      // Power-on flag follows the reset kind
      if (i_evt.power_on) reset_cause_status[`RSW_BIT_POWER_ON] <= 1'b0;
      if (i_evt.brownout || i_evt.power_on) reset_cause_status[`RSW_BIT_BROWNOUT] <= 1'b0;
      if (i_evt.power_on) reset_cause_status[`RSW_BIT_RESET_INSTR] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog software enable
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      soft_watchdog_enable <= `RSW_SOFT_WDOG_EN_RST;
    end else if (wr_wdog) begin
      // Only bit zero of the control byte is stored
      soft_watchdog_enable <= i_bus.wdata[`RSW_BIT_SOFT_WDOG_EN];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_watchdog_run <= 1'b0;
    end else begin
      o_watchdog_run <= i_config_watchdog_enable || soft_watchdog_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      irq_status <= 5'h00;
    end else begin
      // Event wins over a same-cycle clear
      irq_status <= (irq_status & ~(wr_stat ? i_bus.wdata[4:0] : 5'h00)) | flag_clear_evt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      irq_mask <= 5'h00;
    end else if (wr_mask) begin
      irq_mask <= i_bus.wdata[4:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_irq <= 1'b0;
      o_irq_priority_enable <= 1'b0;
      o_soft_brownout_enable <= 1'b0;
    end else begin
      // Registered copies, no decode path to the pins
      o_irq <= |(irq_status & irq_mask);
      o_irq_priority_enable <= reset_cause_status[`RSW_BIT_IRQ_PRIO_EN];
      o_soft_brownout_enable <= reset_cause_status[`RSW_BIT_SOFT_BROWNOUT_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
    end else if (i_bus.rd) begin
      // Unmapped addresses and idle cycles read zero
      unique case (i_bus.addr)
        `RSW_ADDR_RESET_CAUSE: o_rdata <= reset_cause_status;
        `RSW_ADDR_WDOG_CTRL:   o_rdata <= {7'h00, soft_watchdog_enable};
        `RSW_ADDR_IRQ_STATUS:  o_rdata <= {3'h0, irq_status};
        `RSW_ADDR_IRQ_MASK:    o_rdata <= {3'h0, irq_mask};
        default:               o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_CFG_OVERRIDE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_config_watchdog_enable |=> o_watchdog_run)
    else $error("Watchdog stopped while config enable set");
  AST_SW_ON: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (wr_wdog && i_bus.wdata[0]) |=> ##1 o_watchdog_run)
    else $error("Watchdog not on after software enable");
  AST_SW_OFF: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (wr_wdog && !i_bus.wdata[0] && !i_config_watchdog_enable) ##1 !i_config_watchdog_enable
    |=> !o_watchdog_run)
    else $error("Watchdog still on after software disable");
  AST_SW_RESET: assert property (@(posedge i_clk_sys)
    i_srst |=> !soft_watchdog_enable)
    else $error("Software enable not zero after reset");
  AST_UPPER_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_bus.rd && i_bus.addr == `RSW_ADDR_WDOG_CTRL) |=> o_rdata[7:1] == 7'h00)
    else $error("Watchdog control upper bits not zero");
  AST_POR_LOAD: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_evt.power_on |=> !reset_cause_status[`RSW_BIT_POWER_ON] && !reset_cause_status[`RSW_BIT_BROWNOUT])
    else $error("Power-on flag not cleared by power-on");
  AST_TO_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_evt.wdt_timeout |=> !reset_cause_status[`RSW_BIT_WDOG_TIMEOUT])
    else $error("Timeout flag not cleared");
  AST_PD_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_evt.sleep_instr |=> !reset_cause_status[`RSW_BIT_POWER_DOWN] ##1 1'b1)
    else $error("Power-down flag not cleared");
  AST_RI_SET: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (wr_cause && i_bus.wdata[4] && !i_evt.reset_instr) |=> reset_cause_status[`RSW_BIT_RESET_INSTR])
    else $error("Reset-instruction flag not set by software");

  ////////////////////////////////////////////////////////////////////////////
  // Flag and enable checks
  AST_TO_SET: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    ((i_evt.wdt_clear || i_evt.sleep_instr || i_evt.power_on) && !i_evt.wdt_timeout)
    |=> reset_cause_status[`RSW_BIT_WDOG_TIMEOUT])
    else $error("Timeout flag not set by clear, sleep or power-on");
  AST_PD_SET: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    ((i_evt.wdt_clear || i_evt.power_on) && !i_evt.sleep_instr) |=> reset_cause_status[`RSW_BIT_POWER_DOWN])
    else $error("Power-down flag not set");
  AST_RI_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_evt.reset_instr && !i_evt.power_on) |=> !reset_cause_status[`RSW_BIT_RESET_INSTR])
    else $error("Reset-instruction flag not cleared");
  AST_BOR_CLEAR: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    i_evt.brownout |=> !reset_cause_status[`RSW_BIT_BROWNOUT])
    else $error("Brown-out flag not cleared");
  AST_POR_SET_SW: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (wr_cause && i_bus.wdata[`RSW_BIT_POWER_ON] && !i_evt.power_on) |=> reset_cause_status[`RSW_BIT_POWER_ON])
    else $error("Power-on flag not set by software");
  AST_RUN_SOFT_OFF: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (!i_config_watchdog_enable && !soft_watchdog_enable) |=> !o_watchdog_run)
    else $error("Watchdog running with both enables off");
  AST_RUN_SOFT_ON: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (!i_config_watchdog_enable && soft_watchdog_enable) |=> o_watchdog_run)
    else $error("Watchdog stopped with software enable set");
  AST_WDOG_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    wr_wdog |=> soft_watchdog_enable == $past(i_bus.wdata[`RSW_BIT_SOFT_WDOG_EN]))
    else $error("Software enable not loaded by write");
  AST_WDOG_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_bus.rd && i_bus.addr == `RSW_ADDR_WDOG_CTRL) |=> o_rdata[0] == $past(soft_watchdog_enable))
    else $error("Software enable read back wrong");
  AST_RUN_RESET: assert property (@(posedge i_clk_sys)
    i_srst |=> !o_watchdog_run)
    else $error("Watchdog running after reset");
  AST_CAUSE_READ: assert property (@(posedge i_clk_sys) disable iff (i_srst)
    (i_bus.rd && i_bus.addr == `RSW_ADDR_RESET_CAUSE) |=> o_rdata == $past(reset_cause_status))
    else $error("Reset-cause register read back wrong");
  COV_SW_ON: cover property (@(posedge i_clk_sys) wr_wdog && i_bus.wdata[0] && !i_config_watchdog_enable);
  COV_TIMEOUT: cover property (@(posedge i_clk_sys) i_evt.wdt_timeout);
  COV_IRQ: cover property (@(posedge i_clk_sys) o_irq);
  COV_SLEEP: cover property (@(posedge i_clk_sys) i_evt.sleep_instr);
  COV_POWER_ON: cover property (@(posedge i_clk_sys) i_evt.power_on);
endmodule
`default_nettype wire

/* hw/rsw_consts.svh */
/*
 Offsets, field positions, reset values of the reset-status and watchdog control block.
 Assumes inclusion by bare name from hw/.
*/
`ifndef RSW_CONSTS_SVH
`define RSW_CONSTS_SVH

`define RSW_ADDR_RESET_CAUSE   4'h0
`define RSW_ADDR_WDOG_CTRL     4'h1
`define RSW_ADDR_IRQ_STATUS    4'h2
`define RSW_ADDR_IRQ_MASK      4'h3

`define RSW_BIT_IRQ_PRIO_EN      7
`define RSW_BIT_SOFT_BROWNOUT_EN 6
`define RSW_BIT_UNUSED_CAUSE     5
`define RSW_BIT_RESET_INSTR      4
`define RSW_BIT_WDOG_TIMEOUT     3
`define RSW_BIT_POWER_DOWN       2
`define RSW_BIT_POWER_ON         1
`define RSW_BIT_BROWNOUT         0
`define RSW_BIT_SOFT_WDOG_EN     0

`define RSW_RESET_CAUSE_RST    8'h5c
`define RSW_SOFT_WDOG_EN_RST   1'b0
`define RSW_WDOG_CTRL_RST      8'h00
`define RSW_RW_MASK_CAUSE      8'hc0
`define RSW_FLAG_MASK_CAUSE    8'h1f

`endif

/* hw/rsw_pkg.sv */
/*
 Types of the reset-status and watchdog control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package rsw_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rsw_bus_req_type;

  // Device reset causes and hardware events, one-cycle pulses
  typedef struct packed {
    logic reset_instr;
    logic wdt_timeout;
    logic sleep_instr;
    logic wdt_clear;
    logic power_on;
    logic brownout;
  } rsw_event_type;
endpackage
`default_nettype wire

/* tb/tb.sv */
/*
 Self-checking bench of the reset-status and watchdog control block.
 Assumes the design files under hw/ and a single 250 MHz system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
  import rsw_pkg::*;
  logic            clk        = 1'b0;
  logic            srst       = 1'b1;
  logic            cfg_wd     = 1'b0;
  logic            cfg_sb     = 1'b1;
  rsw_bus_req_type bus        = '0;
  rsw_event_type   evt        = '0;
  logic [7:0]      rdata;
  logic            run;
  logic            prio_en;
  logic            soft_bo;
  logic            irq;
  logic [7:0]      m_cause    = 8'h5c;
  logic [7:0]      m_wd       = 8'h00;
  logic [7:0]      m_st       = 8'h00;
  logic [7:0]      m_mk       = 8'h00;
  logic [3:0]      ra;
  logic [7:0]      rdat;
  int              n_mismatch = 0;
  int              n_compared = 0;
  always #2 clk = ~clk;
  rsw_reset_status_wdog i_dut (.i_clk_sys(clk), .i_srst(srst), .i_bus(bus), .o_rdata(rdata), .i_evt(evt),
    .i_config_watchdog_enable(cfg_wd), .i_config_soft_brownout_allow(cfg_sb), .o_watchdog_run(run),
    .o_irq_priority_enable(prio_en), .o_soft_brownout_enable(soft_bo), .o_irq(irq));
  //////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
    case (a)
      4'h0: m_cause = {d[7], d[6] & cfg_sb, 1'b0, m_cause[4:0] | d[4:0]};
      4'h1: m_wd = {7'h00, d[0]};
      4'h2: m_st = m_st & ~{3'h0, d[4:0]};
      4'h3: m_mk = d & 8'h1f;
      default: ;
    endcase
    m_cause[6] = m_cause[6] & cfg_sb;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 chk(nm, exp, rdata);
  endtask
  // Event pulse and its expected effect
  task ev(input int k);
    @(posedge clk) evt <= rsw_event_type'(6'(1 << k));
    @(posedge clk) evt <= '0;
    case (k)
      5: begin m_cause[4] = 1'b0; m_st[4] = 1'b1; end
      4: begin m_cause[3] = 1'b0; m_st[3] = 1'b1; end
      3: begin m_cause[3:2] = 2'b10; m_st[2] = 1'b1; end
      2: m_cause[3:2] = 2'b11;
      1: begin m_cause[4:0] = 5'h1c; m_st[1:0] = 2'b11; end
      default: begin m_cause[0] = 1'b0; m_st[0] = 1'b1; end
    endcase
  endtask
  task rd_all;
    rd(4'h0, m_cause, "reset_cause");
    rd(4'h1, m_wd, "watchdog_ctrl");
    rd(4'h2, m_st, "irq_status");
    rd(4'h3, m_mk, "irq_mask");
    rd(4'h9, 8'h00, "unmapped");
    chk("watchdog_run", {7'h00, cfg_wd | m_wd[0]}, {7'h00, run});
    chk("irq", {7'h00, |(m_st & m_mk)}, {7'h00, irq});
    chk("enables", {6'h00, m_cause[7:6]}, {6'h00, prio_en, soft_bo});
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(8971));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd_all;
    $display("test reset values done");
    wr(4'h1, 8'hff);
    rd_all;
    @(posedge clk) cfg_wd <= 1'b1;
    wr(4'h1, 8'h00);
    rd_all;
    @(posedge clk) cfg_wd <= 1'b0;
    rd_all;
    $display("test watchdog enable done");
    wr(4'h3, 8'h1f);
    for (int k = 5; k >= 0; k--) begin
      ev(k);
      rd_all;
    end
    wr(4'h0, 8'h1f);
    wr(4'h2, 8'h1f);
    rd_all;
    $display("test events done");
    repeat (40) begin
      ra = 4'($urandom % 5);
      rdat = 8'($urandom);
      if (ra == 4'h3)
        rdat = rdat & 8'h1f;
      if ($urandom % 2)
        ev(int'($urandom % 6));
      @(posedge clk) {cfg_wd, cfg_sb} <= 2'($urandom);
      wr(ra, rdat);
      rd_all;
    end
    $display("test random traffic done");
    @(posedge clk) begin
      srst <= 1'b1;
      cfg_wd <= 1'b0;
    end
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    m_cause = {1'b0, cfg_sb, 1'b0, 5'h1c};
    m_wd = 8'h00;
    m_st = 8'h00;
    m_mk = 8'h00;
    rd_all;
    $display("test mid-run reset done");
    test_done;
  end
  initial begin
    #20000;
    n_mismatch++;
    $display("watchdog expired");
    test_done;
  end
endmodule
`default_nettype wire
